// ### core/lhi_pkg.sv
package lhi_pkg;

  // ==========================================================
  // Strap decode
  localparam logic [1:0] STRAP_SPI4 = 2'h0;
  localparam logic [1:0] STRAP_SHARED = 2'h1;
  localparam logic [1:0] STRAP_STROBE = 2'h2;
  localparam logic [1:0] STRAP_ENABLE = 2'h3;
  localparam logic [1:0] UP_I2C = 2'h3;

  // ==========================================================
  // Serial framing
  localparam logic [3:0] SPI4_LAST_BIT = 4'h7;
  localparam logic [3:0] SPI3_LAST_BIT = 4'h8;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam int HDR_CONTENT_POS = 1;
  localparam int HDR_RW_POS = 0;
  localparam logic [1:0] WARM_CAPTURE = 2'h2;
  localparam logic [1:0] WARM_DONE = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LHI_STROBE,
    LHI_ENABLE,
    LHI_SPI4,
    LHI_SPI3,
    LHI_I2C
  } lhi_mode_e;

  typedef enum logic [2:0] {
    I_IDLE,
    I_HDR,
    I_HDR_ACK,
    I_WR,
    I_WR_ACK,
    I_RD,
    I_RD_ACK
  } lhi_i2c_e;

  typedef struct packed {
    logic [1:0] bus_mode;
    logic [7:0] data;
    logic first_strobe;
    logic second_strobe;
    logic cmd_data_select;
    logic [1:0] cs;
  } lhi_pins_s;

  typedef struct packed {
    logic [7:0] byte_val;
    logic is_data;
  } lhi_token_s;

  // ==========================================================
  // Helpers
  function automatic lhi_mode_e lhi_decode_mode(input logic [1:0] strap, input logic [1:0] up);
    case (strap)
      STRAP_STROBE: lhi_decode_mode = LHI_STROBE;
      STRAP_ENABLE: lhi_decode_mode = LHI_ENABLE;
      STRAP_SPI4: lhi_decode_mode = LHI_SPI4;
      default: lhi_decode_mode = (up == UP_I2C) ? LHI_I2C : LHI_SPI3;
    endcase
  endfunction

  // Chip select: cs[0] active low, cs[1] active high
  function automatic logic lhi_selected(input logic [1:0] cs);
    lhi_selected = ~cs[0] & cs[1];
  endfunction

  // Internal read or write pulse from the two strobe pins
  function automatic logic lhi_strobe(input lhi_mode_e m, input lhi_pins_s p, input logic rd);
    if (m == LHI_STROBE) begin
      lhi_strobe = rd ? ~p.second_strobe : ~p.first_strobe;
    end else begin
      lhi_strobe = p.second_strobe & (rd ? p.first_strobe : ~p.first_strobe);
    end
  endfunction

endpackage

// ### core/lhi_serial_rx.sv
`timescale 1ns/1ps
module lhi_serial_rx import lhi_pkg::*; (
  // Link clock and resets
  input wire logic serial_clk_in,
  input wire logic rst_n_in,
  input wire logic select_in,
  // Mode and pins
  input wire logic three_wire_in,
  input wire logic sdata_in,
  input wire logic cmd_data_select_in,
  // Finished token
  output lhi_token_s token_out,
  output logic token_toggle_out
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] shift;
    logic flag;
  } lhi_bits_s;

  typedef struct packed {
    lhi_token_s token;
    logic toggle;
  } lhi_hold_s;

  lhi_bits_s q;
  lhi_bits_s next_q;
  lhi_hold_s h;
  lhi_hold_s next_h;
  logic bit_rst_n;

  // Deselect clears the partial byte, not the finished token
  assign bit_rst_n = rst_n_in & select_in;

  // ==========================================================
  // Shifter
  always_comb begin
    next_q = q;
    next_h = h;
    if (three_wire_in && q.cnt == 4'h0) begin
      next_q.flag = sdata_in;
    end else begin
      next_q.shift = {q.shift[6:0], sdata_in};
    end
    if (q.cnt == (three_wire_in ? SPI3_LAST_BIT : SPI4_LAST_BIT)) begin
      next_q.cnt = 4'h0;
      if (!three_wire_in) begin
        next_q.flag = cmd_data_select_in;
      end
      next_h.token.byte_val = next_q.shift;
      next_h.token.is_data = next_q.flag;
      next_h.toggle = ~h.toggle;
    end else begin
      next_q.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge serial_clk_in or negedge bit_rst_n) begin
    if (!bit_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  assign token_out = h.token;
  assign token_toggle_out = h.toggle;

endmodule

// ### core/lhi_host_port.sv
`timescale 1ns/1ps
// Behaviour
// - Straps pick mode: 10 strobe pair, 11 enable style, 00 four-wire, 01 shared.
// - Parallel RAM reads pass a one-stage pipe; one dummy read after address set.
// - RAM writes unpipelined: bus byte written at the end of each write pulse.
// - Chip select gates serial modes and clears the serial bit counter.
// - Four-wire mode shifts eight bits, MSB first, on rising serial clock.
// - Four-wire mode takes command/data level at the last bit; low is command.
// - Serial data bytes are written to RAM at the last clock of the byte.
// - Three-wire frames are nine bits: command/data flag, then eight bits MSB first.
// - In I2C mode the two chip-select pins are address bits A3 and A2.
// - I2C sequence: START, header with address, content bit, direction bit.
// - Direction and content stay fixed within one I2C sequence.
// - Device acknowledges header; bytes MSB first until STOP or host NAK.
// - First I2C display-data read byte is a dummy.
module lhi_host_port import lhi_pkg::*; #(
  parameter logic [3:0] I2C_ADDR_TOP = 4'h7
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Serial clock (same pin as D0)
  input wire logic serial_clk_in,
  // Host pins
  input wire logic [1:0] bus_mode_strap_in,
  input wire logic [7:0] data_in,
  input wire logic first_strobe_pin_in,
  input wire logic second_strobe_pin_in,
  input wire logic cmd_data_select_in,
  input wire logic [1:0] chip_select_in,
  // Host pin drivers
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  // Core side
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic ram_wr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_rd_out,
  input wire logic [7:0] ram_rdata_in,
  input wire logic [7:0] status_in,
  output lhi_mode_e mode_out
);

  typedef struct packed {
    lhi_pins_s s1;
    lhi_pins_s s2;
    lhi_pins_s s3;
    logic [2:0] tog;
    logic [1:0] warm;
    lhi_mode_e mode;
    logic [7:0] pipe;
    lhi_i2c_e st;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic hdr_content;
    logic hdr_rw;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic ram_wr;
    logic [7:0] ram_wdata;
    logic ram_rd;
    logic [7:0] data_o;
    logic data_oe;
    logic sda_o;
    logic sda_oe;
  } lhi_state_s;

  lhi_state_s q;
  lhi_state_s next_q;
  lhi_pins_s pins;
  lhi_token_s tok;
  logic tok_toggle;
  logic par_mode;
  logic spi_mode;
  logic sel;
  logic wr_cur;
  logic wr_prev;
  logic rd_cur;
  logic rd_prev;
  logic tok_event;
  logic scl;
  logic sda;
  logic i2c_start;
  logic i2c_stop;
  logic scl_rise;
  logic scl_fall;
  logic addr_hit;

  assign pins = '{bus_mode: bus_mode_strap_in, data: data_in,
                  first_strobe: first_strobe_pin_in, second_strobe: second_strobe_pin_in,
                  cmd_data_select: cmd_data_select_in, cs: chip_select_in};

  // ==========================================================
  // Serial receiver on the link clock
  lhi_serial_rx u_rx (
    .serial_clk_in(serial_clk_in),
    .rst_n_in(rst_n_in),
    .select_in(lhi_selected(chip_select_in)),
    .three_wire_in(q.mode == LHI_SPI3),
    .sdata_in(data_in[3]),
    .cmd_data_select_in(cmd_data_select_in),
    .token_out(tok),
    .token_toggle_out(tok_toggle)
  );

  // ==========================================================
  // Decoded pin events
  assign par_mode = (q.warm == WARM_DONE) && (q.mode == LHI_STROBE || q.mode == LHI_ENABLE);
  assign spi_mode = (q.warm == WARM_DONE) && (q.mode == LHI_SPI4 || q.mode == LHI_SPI3);
  assign sel = lhi_selected(q.s2.cs);
  assign wr_cur = lhi_strobe(q.mode, q.s2, 1'b0);
  assign wr_prev = lhi_strobe(q.mode, q.s3, 1'b0);
  assign rd_cur = lhi_strobe(q.mode, q.s2, 1'b1);
  assign rd_prev = lhi_strobe(q.mode, q.s3, 1'b1);
  assign tok_event = q.tog[2] ^ q.tog[1];
  assign scl = q.s2.data[0];
  assign sda = q.s2.data[3];
  assign i2c_start = scl && q.s3.data[0] && q.s3.data[3] && !sda;
  assign i2c_stop = scl && q.s3.data[0] && !q.s3.data[3] && sda;
  assign scl_rise = scl && !q.s3.data[0];
  assign scl_fall = !scl && q.s3.data[0];
  assign addr_hit = q.sh[7:2] == {I2C_ADDR_TOP, q.s2.cs};

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] rd_byte;
    logic adv;
    rd_byte = 8'h00;
    adv = 1'b0;
    next_q = q;
    next_q.s1 = pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.tog = {q.tog[1:0], tok_toggle};
    next_q.cmd_valid = 1'b0;
    next_q.ram_wr = 1'b0;
    next_q.ram_rd = 1'b0;
    next_q.data_oe = par_mode && sel && rd_cur;
    if (q.warm != WARM_DONE) begin
      next_q.warm = q.warm + 2'h1;
      if (q.warm == WARM_CAPTURE) begin
        next_q.mode = lhi_decode_mode(q.s2.bus_mode, q.s2.data[7:6]);
      end
    end
    if (par_mode && sel) begin
      if (wr_prev && !wr_cur) begin
        if (q.s3.cmd_data_select) begin
          next_q.ram_wr = 1'b1;
          next_q.ram_wdata = q.s3.data;
        end else begin
          next_q.cmd_valid = 1'b1;
          next_q.cmd_byte = q.s3.data;
        end
      end
      if (rd_cur && !rd_prev) begin
        next_q.data_o = q.s2.cmd_data_select ? q.pipe : status_in;
      end
      if (rd_prev && !rd_cur && q.s3.cmd_data_select) begin
        adv = 1'b1;
      end
    end
    if (spi_mode && tok_event) begin
      if (tok.is_data) begin
        next_q.ram_wr = 1'b1;
        next_q.ram_wdata = tok.byte_val;
      end else begin
        next_q.cmd_valid = 1'b1;
        next_q.cmd_byte = tok.byte_val;
      end
    end
    if (q.warm == WARM_DONE && q.mode == LHI_I2C) begin
      if (i2c_start) begin
        next_q.st = I_HDR;
        next_q.bit_cnt = 4'h0;
        next_q.sda_oe = 1'b0;
      end else if (i2c_stop) begin
        next_q.st = I_IDLE;
        next_q.sda_oe = 1'b0;
      end else if (scl_rise) begin
        case (q.st)
          I_HDR, I_WR: begin
            next_q.sh = {q.sh[6:0], sda};
            next_q.bit_cnt = q.bit_cnt + 4'h1;
          end
          I_RD: begin
            next_q.bit_cnt = q.bit_cnt + 4'h1;
          end
          I_RD_ACK: begin
            if (sda) begin
              next_q.st = I_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (q.st)
          I_HDR: begin
            if (q.bit_cnt == I2C_BYTE_BITS) begin
              if (addr_hit) begin
                next_q.st = I_HDR_ACK;
                next_q.sda_oe = 1'b1;
                next_q.hdr_content = q.sh[HDR_CONTENT_POS];
                next_q.hdr_rw = q.sh[HDR_RW_POS];
              end else begin
                next_q.st = I_IDLE;
              end
            end
          end
          I_WR: begin
            if (q.bit_cnt == I2C_BYTE_BITS) begin
              next_q.st = I_WR_ACK;
              next_q.sda_oe = 1'b1;
              if (q.hdr_content) begin
                next_q.ram_wr = 1'b1;
                next_q.ram_wdata = q.sh;
              end else begin
                next_q.cmd_valid = 1'b1;
                next_q.cmd_byte = q.sh;
              end
            end
          end
          I_HDR_ACK, I_WR_ACK, I_RD_ACK: begin
            next_q.bit_cnt = 4'h0;
            if (q.hdr_rw) begin
              rd_byte = q.hdr_content ? q.pipe : status_in;
              adv = q.hdr_content;
              next_q.sh = rd_byte;
              next_q.sda_oe = ~rd_byte[7];
              next_q.st = I_RD;
            end else begin
              next_q.sda_oe = 1'b0;
              next_q.st = I_WR;
            end
          end
          I_RD: begin
            if (q.bit_cnt == I2C_BYTE_BITS) begin
              next_q.sda_oe = 1'b0;
              next_q.st = I_RD_ACK;
            end else begin
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe = ~q.sh[6];
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (adv) begin
      next_q.pipe = ram_rdata_in;
      next_q.ram_rd = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= next_q;
    end
  end

  assign data_out = q.data_o;
  assign data_oe_out = q.data_oe;
  assign sda_out = q.sda_o;
  assign sda_oe_out = q.sda_oe;
  assign cmd_valid_out = q.cmd_valid;
  assign cmd_byte_out = q.cmd_byte;
  assign ram_wr_out = q.ram_wr;
  assign ram_wdata_out = q.ram_wdata;
  assign ram_rd_out = q.ram_rd;
  assign mode_out = q.mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_par_wr_end;
    ce_in && par_mode && sel && wr_prev && !wr_cur;
  endsequence

  sequence s_par_rd_end;
    ce_in && par_mode && sel && rd_prev && !rd_cur && q.s3.cmd_data_select;
  endsequence

  property p_mode_map;
    ce_in && q.warm == WARM_CAPTURE |=>
      mode_out == lhi_decode_mode($past(q.s2.bus_mode), $past(q.s2.data[7:6]));
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode not decoded from straps");

  property p_mode_hold;
    q.warm == WARM_DONE |=> $stable(mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

  property p_par_data_wr;
    s_par_wr_end ##0 q.s3.cmd_data_select |=> ram_wr_out && ram_wdata_out == $past(q.s3.data);
  endproperty
  a_par_data_wr: assert property (p_par_data_wr) else $error("parallel RAM write missing");

  property p_par_cmd_wr;
    s_par_wr_end ##0 !q.s3.cmd_data_select |=> cmd_valid_out && !ram_wr_out;
  endproperty
  a_par_cmd_wr: assert property (p_par_cmd_wr) else $error("parallel command missing");

  property p_rd_pipe;
    s_par_rd_end |=> ram_rd_out && q.pipe == $past(ram_rdata_in);
  endproperty
  a_rd_pipe: assert property (p_rd_pipe) else $error("read pipe did not advance");

  property p_serial_data;
    ce_in && spi_mode && tok_event && tok.is_data |=>
      ram_wr_out && ram_wdata_out == $past(tok.byte_val);
  endproperty
  a_serial_data: assert property (p_serial_data) else $error("serial data byte lost");

  property p_hdr_ack;
    q.st == I_HDR_ACK |-> sda_oe_out && !sda_out;
  endproperty
  a_hdr_ack: assert property (p_hdr_ack) else $error("header not acknowledged");

  property p_addr_miss;
    ce_in && q.mode == LHI_I2C && q.st == I_HDR && scl_fall && !i2c_start && !i2c_stop
      && q.bit_cnt == I2C_BYTE_BITS && !addr_hit |=> q.st == I_IDLE && !sda_oe_out;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("acked foreign address");

  property p_hdr_fixed;
    q.st != I_IDLE && q.st != I_HDR |=> $stable(q.hdr_content) && $stable(q.hdr_rw);
  endproperty
  a_hdr_fixed: assert property (p_hdr_fixed) else $error("header changed mid sequence");

endmodule

// ### tb/lhi_host_model.sv
`timescale 1ns/1ps
module lhi_host_model import lhi_pkg::*; (
  // Device side
  input wire logic mclk_in,
  input wire logic [7:0] data_out_in,
  input wire logic data_oe_in,
  input wire logic sda_oe_in,
  // Host pins and resolved bus
  output lhi_pins_s pins_out,
  output logic [7:0] bus_out
);
  lhi_pins_s p;
  logic [7:0] last;
  logic drv;
  assign pins_out = p;
  // Device drive, else host, else stale value inverted; SDA open drain
  always_comb begin
    if (data_oe_in) bus_out = data_out_in;
    else if (drv) bus_out = {p.data[7:4], p.data[3] & ~sda_oe_in, p.data[2:0]};
    else bus_out = ~last;
  end

  // ==========================================================
  // Pin setup and parallel cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic setup(input logic [1:0] strap, input logic [1:0] up);
    p.bus_mode = strap;
    p.data = {up, 6'h00};
    last = p.data;
    drv = 1'b1;
    p.first_strobe = (strap == STRAP_STROBE);
    p.second_strobe = (strap == STRAP_STROBE);
    p.cmd_data_select = 1'b0;
    p.cs = 2'b01;
  endtask
  task automatic par(input logic rd, input logic is_dat, input logic [7:0] b);
    p.cs = 2'b10;
    p.cmd_data_select = is_dat;
    p.data = b;
    last = b;
    drv = !rd;
    if (p.bus_mode == STRAP_ENABLE) p.first_strobe = rd;
    cyc(2);
    if (p.bus_mode == STRAP_ENABLE) p.second_strobe = 1'b1;
    else if (rd) p.second_strobe = 1'b0;
    else p.first_strobe = 1'b0;
    cyc(10);
    if (p.bus_mode == STRAP_ENABLE) p.second_strobe = 1'b0;
    else {p.first_strobe, p.second_strobe} = 2'b11;
    cyc(4);
    drv = 1'b0;
    p.cs = 2'b01;
    cyc(8);
  endtask

  // ==========================================================
  // Serial clock only runs inside frames
  task automatic sck_bit(input logic b);
    p.data[3] = b;
    #32 p.data[0] = 1'b1;
    #32 p.data[0] = 1'b0;
  endtask
  task automatic sel(input logic on);
    if (on) begin
      p.cs = 2'b10;
      #13.3;
    end else begin
      #40 p.cs = 2'b01;
      p.data[3] = ~p.data[3];
      cyc(20);
    end
  endtask
  task automatic bits8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) sck_bit(b[i]);
  endtask
  task automatic bits9(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) sck_bit(v[i]);
  endtask
  task automatic i2c_start();
    p.data[3] = 1'b1;
    p.data[0] = 1'b1;
    #32 p.data[3] = 1'b0;
    #32 p.data[0] = 1'b0;
  endtask
  task automatic i2c_stop();
    p.data[3] = 1'b0;
    #32 p.data[0] = 1'b1;
    #32 p.data[3] = 1'b1;
    cyc(20);
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    bits8(b);
    p.data[3] = 1'b1;
    #32 p.data[0] = 1'b1;
    #8 ack = sda_oe_in;
    #24 p.data[0] = 1'b0;
  endtask
  // Read one byte from the device, then ACK or NAK it
  task automatic i2c_rd(input logic nak, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      p.data[3] = 1'b1;
      #32 v[i] = bus_out[3];
      p.data[0] = 1'b1;
      #32 p.data[0] = 1'b0;
    end
    p.data[3] = nak;
    #32 p.data[0] = 1'b1;
    #32 p.data[0] = 1'b0;
  endtask
endmodule

// ### tb/test_lcd_driver_host_interface.sv
`timescale 1ns/1ps
module test_lcd_driver_host_interface import lhi_pkg::*;;
  localparam logic [3:0] ADDR_TOP = 4'h9; // arbitrary
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rdata = 8'h00;
  logic [7:0] status = 8'h00;
  logic [7:0] lfsr = 8'h50;
  lhi_pins_s pins;
  logic [7:0] bus, data_out, cmd_b, ram_wd, b, exp_b;
  logic data_oe, sda_oe, sda_o, cmd_v, ram_wr, ram_rd, ack, oe_q;
  lhi_mode_e mode;
  lhi_token_s wq[$];
  logic [8:0] rq[$];
  int mismatches = 0;
  int n_checks = 0;
  int n_rd = 0;
  int exp_rd = 0;

  lhi_host_model i_lhi_host_model (.mclk_in(mclk), .data_out_in(data_out),
    .data_oe_in(data_oe), .sda_oe_in(sda_oe), .pins_out(pins), .bus_out(bus));
  lhi_host_port #(.I2C_ADDR_TOP(ADDR_TOP)) i_lhi_host_port (.mclk_in(mclk),
    .rst_n_in(rst_n), .ce_in(ce), .serial_clk_in(bus[0]),
    .bus_mode_strap_in(pins.bus_mode), .data_in(bus),
    .first_strobe_pin_in(pins.first_strobe), .second_strobe_pin_in(pins.second_strobe),
    .cmd_data_select_in(pins.cmd_data_select), .chip_select_in(pins.cs),
    .data_out(data_out), .data_oe_out(data_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .cmd_valid_out(cmd_v), .cmd_byte_out(cmd_b), .ram_wr_out(ram_wr),
    .ram_wdata_out(ram_wd), .ram_rd_out(ram_rd), .ram_rdata_in(rdata),
    .status_in(status), .mode_out(mode));

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Checking
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Results taken mid-cycle, away from launching edges
  always @(negedge mclk) begin
    if (ram_wr === 1'b1 || cmd_v === 1'b1) begin
      if (wq.size() == 0) check(9'h1FF, 9'h000);
      else check({(ram_wr === 1'b1) ? ram_wd : cmd_b, ram_wr}, wq.pop_front());
    end
    if (data_oe === 1'b1 && oe_q !== 1'b1 && rq.size() > 0) begin
      if (rq[0][8]) void'(rq.pop_front());
      else check({1'b0, data_out}, rq.pop_front());
    end
    oe_q = data_oe;
    if (ram_rd === 1'b1) n_rd++;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // Sequence
  // Clock enable held low across release: mode must stay at its reset value
  task automatic boot(input logic [1:0] strap, input logic [1:0] up, input lhi_mode_e m);
    rst_n = 1'b0;
    ce = 1'b0;
    i_lhi_host_model.setup(strap, up);
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    i_lhi_host_model.cyc(6);
    check({6'h00, mode}, {6'h00, LHI_STROBE});
    ce = 1'b1;
    i_lhi_host_model.cyc(12);
    check({6'h00, mode}, {6'h00, m});
  endtask
  task automatic spi_byte(input logic is_dat, input logic three);
    b = rnd();
    wq.push_back('{b, is_dat});
    i_lhi_host_model.sel(1'b1);
    if (three) i_lhi_host_model.bits9({is_dat, b});
    else begin
      i_lhi_host_model.p.cmd_data_select = is_dat;
      i_lhi_host_model.bits8(b);
    end
    i_lhi_host_model.sel(1'b0);
  endtask

  initial begin
    for (int k = 0; k < 2; k++) begin
      if (k == 0) boot(STRAP_STROBE, 2'h0, LHI_STROBE);
      else boot(STRAP_ENABLE, 2'h0, LHI_ENABLE);
      for (int c = 1; c >= 0; c--) begin
        b = rnd();
        wq.push_back('{b, c[0]});
        i_lhi_host_model.par(1'b0, c[0], b);
      end
      status = rnd();
      rq.push_back({1'b0, status});
      i_lhi_host_model.par(1'b1, 1'b0, 8'h00);
      rdata = rnd();
      rq.push_back(9'h100);
      i_lhi_host_model.par(1'b1, 1'b1, 8'h00);
      rq.push_back({1'b0, rdata});
      rdata = rnd();
      i_lhi_host_model.par(1'b1, 1'b1, 8'h00);
      exp_rd += 2;
    end
    boot(STRAP_SPI4, 2'h0, LHI_SPI4);
    i_lhi_host_model.sel(1'b1);
    repeat (5) i_lhi_host_model.sck_bit(lfsr[0]);
    i_lhi_host_model.sel(1'b0);
    spi_byte(1'b1, 1'b0);
    spi_byte(1'b0, 1'b0);
    boot(STRAP_SHARED, 2'h2, LHI_SPI3);
    spi_byte(1'b1, 1'b1);
    spi_byte(1'b0, 1'b1);
    boot(STRAP_SHARED, UP_I2C, LHI_I2C);
    i_lhi_host_model.i2c_start();
    i_lhi_host_model.i2c_byte({~ADDR_TOP, 4'h6}, ack);
    check({8'h00, ack}, 9'h000);
    i_lhi_host_model.i2c_stop();
    for (int c = 1; c >= 0; c--) begin
      b = rnd();
      wq.push_back('{b, c[0]});
      i_lhi_host_model.i2c_start();
      i_lhi_host_model.i2c_byte({ADDR_TOP, 2'b01, c[0], 1'b0}, ack);
      check({8'h00, ack}, 9'h001);
      check({8'h00, sda_o}, 9'h000);
      i_lhi_host_model.i2c_byte(b, ack);
      check({8'h00, ack}, 9'h001);
      i_lhi_host_model.i2c_stop();
    end
    // Data read: first byte is a dummy, second is the RAM byte
    rdata = rnd();
    exp_b = rdata;
    i_lhi_host_model.i2c_start();
    i_lhi_host_model.i2c_byte({ADDR_TOP, 2'b01, 2'b11}, ack);
    check({8'h00, ack}, 9'h001);
    i_lhi_host_model.i2c_rd(1'b0, b);
    rdata = rnd();
    i_lhi_host_model.i2c_rd(1'b1, b);
    check({1'b0, b}, {1'b0, exp_b});
    i_lhi_host_model.i2c_stop();
    exp_rd += 2;
    check(9'(wq.size()), 9'h000);
    check(9'(rq.size()), 9'h000);
    check(9'(n_rd), 9'(exp_rd));
    end_sim();
  end
endmodule
